//--- core/aofp_fifo.sv
// Empty unit: the buffer module is declared in the top module's file
`default_nettype none
`default_nettype wire

//--- core/aofp_pkg.sv
// Package: register map, field positions, reset values and sample types
`default_nettype none
package aofp_pkg;
    // Widths
    localparam int RES_W = 18;
    localparam int OUT_W = 24;
    localparam int ADDR_W = 8;
    localparam int REG_W = 16;
    localparam int FIFO_DEPTH = 16;
    // Register offsets
    localparam logic [7:0] OFF_FORMAT = 8'h0D;
    localparam logic [7:0] OFF_SCRAMBLE = 8'h12;
    localparam logic [7:0] OFF_PAT_CTRL = 8'h13;
    localparam logic [7:0] OFF_PAT_W0_LOW = 8'h14;
    localparam logic [7:0] OFF_PAT_MIX = 8'h15;
    localparam logic [7:0] OFF_PAT_W1_HIGH = 8'h16;
    // Reset values
    localparam logic [15:0] RST_FORMAT = 16'h2002;
    localparam logic [15:0] RST_SCRAMBLE = 16'h0002;
    localparam logic [15:0] RST_PAT_CTRL = 16'h0000;
    localparam logic [15:0] RST_PAT_WORD = 16'h0000;
    // Field positions
    localparam int FMT_BIT = 13;
    localparam int GAIN_HI = 8;
    localparam int GAIN_LO = 7;
    localparam int XOR_BIT = 3;
    localparam int PEN_BIT = 1;
    localparam int PSEL_HI = 3;
    localparam int PSEL_LO = 2;
    localparam int INC_HI = 7;
    localparam int INC_LO = 4;
    localparam logic [1:0] GAIN_ALL_ON = 2'h3;
    // Pattern kinds
    typedef enum logic [1:0] {
        AOFP_PAT_FIX0 = 2'b00,
        AOFP_PAT_FIX1 = 2'b01,
        AOFP_PAT_RAMP = 2'b10,
        AOFP_PAT_ALT = 2'b11
    } aofp_pat_e;
    // Raw converter results, two's complement
    typedef struct packed {
        logic [RES_W-1:0] a;
        logic [RES_W-1:0] b;
    } aofp_raw_s;
    // Output words toward the host
    typedef struct packed {
        logic [OUT_W-1:0] a;
        logic [OUT_W-1:0] b;
    } aofp_out_s;
endpackage
`default_nettype wire

//--- core/aofp_top.sv
// Output format, scramble and channel A test pattern register bank
//
// The implementer's own choice: the strobed register port.
`default_nettype none
// Contract
// - Format bit 13 of 0Dh picks straight binary (0) or two's complement (1).
// - Gain field bits 8-7 of 0Dh: 0 disables, 3 enables calibration everywhere.
// - Scramble bit 3 of 12h XORs each result with its own LSB.
// - Pattern enable bit 1 of 13h replaces channel A results by the pattern.
// - Select bits 3-2 of 13h: 0/1 fixed word 0, 2 ramp, 3 alternate.
// - Ramp advances by N+1 per step, N from bits 7-4 of 13h.
// - Register 14h holds low 16 bits of pattern word 0, read/write, reset 0.
// - Reset values: 0Dh 2002h, 12h 2h, 13h and 14h zero.
// - Pattern words are 24 bits, spread over 14h, 15h and 16h.
module aofp_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [aofp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [aofp_pkg::REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [aofp_pkg::REG_W-1:0] reg_rdata,
    // Calibration control
    output logic gain_cal_en,
    // Converter results
    input wire logic samp_valid,
    output logic samp_ready,
    input wire aofp_pkg::aofp_raw_s samp_data,
    // Output lanes toward the host
    output logic out_valid,
    input wire logic out_ready,
    output aofp_pkg::aofp_out_s out_data
);
    localparam int RW = aofp_pkg::RES_W;
    localparam int OW = aofp_pkg::OUT_W;
    localparam int PW = $bits(aofp_pkg::aofp_out_s);

    logic [15:0] reg_format;
    logic [15:0] reg_scramble;
    logic [15:0] reg_pat_ctrl;
    logic [15:0] reg_w0_low;
    logic [15:0] reg_mix;
    logic [15:0] reg_w1_high;
    logic [OW-1:0] pat_word0;
    logic [OW-1:0] pat_word1;
    logic [OW-1:0] ramp_val;
    logic [OW-1:0] ramp_step;
    logic alt_sel;
    logic pat_on;
    aofp_pkg::aofp_pat_e pat_kind;
    logic [OW-1:0] pat_val;
    aofp_pkg::aofp_out_s proc;
    logic push;
    logic fifo_valid;
    logic fifo_pop;
    aofp_pkg::aofp_out_s fifo_data;

    ////////////////////////////////////////////////////////////////////////
    // Encode one result: format, then scramble and extend to the lane width
    function automatic logic [OW-1:0] encode(input logic [RW-1:0] raw,
                                             input logic twos, input logic scr);
        logic [RW-1:0] v;
        v = twos ? raw : {~raw[RW-1], raw[RW-2:0]};
        v = scr ? (v ^ {RW{v[0]}}) : v;
        return twos ? {{(OW-RW){v[RW-1]}}, v} : {{(OW-RW){1'b0}}, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_format <= aofp_pkg::RST_FORMAT;
            reg_scramble <= aofp_pkg::RST_SCRAMBLE;
            reg_pat_ctrl <= aofp_pkg::RST_PAT_CTRL;
            reg_w0_low <= aofp_pkg::RST_PAT_WORD;
            reg_mix <= aofp_pkg::RST_PAT_WORD;
            reg_w1_high <= aofp_pkg::RST_PAT_WORD;
        end else if (reg_wr) begin
            if (reg_addr == aofp_pkg::OFF_FORMAT) begin
                reg_format <= reg_wdata;
            end else if (reg_addr == aofp_pkg::OFF_SCRAMBLE) begin
                reg_scramble <= reg_wdata;
            end else if (reg_addr == aofp_pkg::OFF_PAT_CTRL) begin
                reg_pat_ctrl <= reg_wdata;
            end else if (reg_addr == aofp_pkg::OFF_PAT_W0_LOW) begin
                reg_w0_low <= reg_wdata;
            end else if (reg_addr == aofp_pkg::OFF_PAT_MIX) begin
                reg_mix <= reg_wdata;
            end else if (reg_addr == aofp_pkg::OFF_PAT_W1_HIGH) begin
                reg_w1_high <= reg_wdata;
            end
        end
    end

    // Register reads, data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr == aofp_pkg::OFF_FORMAT) begin
                reg_rdata <= reg_format;
            end else if (reg_addr == aofp_pkg::OFF_SCRAMBLE) begin
                reg_rdata <= reg_scramble;
            end else if (reg_addr == aofp_pkg::OFF_PAT_CTRL) begin
                reg_rdata <= reg_pat_ctrl;
            end else if (reg_addr == aofp_pkg::OFF_PAT_W0_LOW) begin
                reg_rdata <= reg_w0_low;
            end else if (reg_addr == aofp_pkg::OFF_PAT_MIX) begin
                reg_rdata <= reg_mix;
            end else if (reg_addr == aofp_pkg::OFF_PAT_W1_HIGH) begin
                reg_rdata <= reg_w1_high;
            end else begin
                reg_rdata <= 16'h0000;
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Calibration enable only for the all-on code
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            gain_cal_en <= 1'b0;
        end else begin
            gain_cal_en <= reg_format[aofp_pkg::GAIN_HI:aofp_pkg::GAIN_LO]
                == aofp_pkg::GAIN_ALL_ON;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pattern generator
    assign pat_word0 = {reg_mix[7:0], reg_w0_low};
    assign pat_word1 = {reg_w1_high, reg_mix[15:8]};
    assign pat_on = reg_pat_ctrl[aofp_pkg::PEN_BIT];
    assign pat_kind = aofp_pkg::aofp_pat_e'(reg_pat_ctrl[aofp_pkg::PSEL_HI:aofp_pkg::PSEL_LO]);
    assign ramp_step = OW'(reg_pat_ctrl[aofp_pkg::INC_HI:aofp_pkg::INC_LO]) + OW'(1);
    assign push = samp_valid && samp_ready;

    always_comb begin
        case (pat_kind)
            aofp_pkg::AOFP_PAT_RAMP: pat_val = ramp_val;
            aofp_pkg::AOFP_PAT_ALT: pat_val = alt_sel ? pat_word1 : pat_word0;
            default: pat_val = pat_word0;
        endcase
    end

    // Ramp advances per output sample and wraps at the lane width
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ramp_val <= '0;
        end else if (push && pat_on && pat_kind == aofp_pkg::AOFP_PAT_RAMP) begin
            ramp_val <= OW'(ramp_val + ramp_step);
        end
    end

    // Alternate word select toggles per output sample
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            alt_sel <= 1'b0;
        end else if (push && pat_on && pat_kind == aofp_pkg::AOFP_PAT_ALT) begin
            alt_sel <= ~alt_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data path into the FIFO
    always_comb begin
        proc.b = encode(samp_data.b, reg_format[aofp_pkg::FMT_BIT],
            reg_scramble[aofp_pkg::XOR_BIT]);
        proc.a = pat_on ? pat_val : encode(samp_data.a, reg_format[aofp_pkg::FMT_BIT],
            reg_scramble[aofp_pkg::XOR_BIT]);
    end

    aofp_fifo #(
        .W(PW),
        .DEPTH(aofp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_valid(samp_valid),
        .in_ready(samp_ready),
        .in_data(proc),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // Output register stage
    assign fifo_pop = fifo_valid && (!out_valid || out_ready);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (fifo_pop) begin
            out_valid <= 1'b1;
            out_data <= fifo_data;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_fmt_binary: assert property (
        push && !reg_format[aofp_pkg::FMT_BIT] && !reg_scramble[aofp_pkg::XOR_BIT]
        |-> proc.b == {6'h00, ~samp_data.b[RW-1], samp_data.b[RW-2:0]})
        else $error("straight binary encoding wrong");
    chk_fmt_twos: assert property (
        push && reg_format[aofp_pkg::FMT_BIT] && !reg_scramble[aofp_pkg::XOR_BIT]
        |-> proc.b == {{6{samp_data.b[RW-1]}}, samp_data.b})
        else $error("two's complement encoding wrong");
    chk_gain_follow: assert property (
        reg_wr && reg_addr == aofp_pkg::OFF_FORMAT
        |=> ##1 gain_cal_en == ($past(reg_wdata[8:7], 2) == 2'h3))
        else $error("gain enable does not follow field");
    chk_xor_lsb: assert property (
        push && reg_scramble[aofp_pkg::XOR_BIT] |-> proc.b[0] == 1'b0)
        else $error("scrambled result lsb not zero");
    chk_pat_fixed: assert property (
        push && pat_on && !reg_pat_ctrl[aofp_pkg::PSEL_HI] |-> proc.a == pat_word0)
        else $error("fixed pattern not word 0");
    chk_pat_off: assert property (
        push && !pat_on && reg_format[aofp_pkg::FMT_BIT] && !reg_scramble[aofp_pkg::XOR_BIT]
        |-> proc.a[RW-1:0] == samp_data.a)
        else $error("result replaced while pattern off");
    chk_ramp_step: assert property (
        push && pat_on && pat_kind == aofp_pkg::AOFP_PAT_RAMP && !reg_wr
        |=> ramp_val == OW'($past(ramp_val) + OW'($past(reg_pat_ctrl[7:4])) + OW'(1)))
        else $error("ramp step wrong");
    chk_alt_swap: assert property (
        push && pat_on && pat_kind == aofp_pkg::AOFP_PAT_ALT |=> alt_sel != $past(alt_sel))
        else $error("alternate select did not swap");
    chk_w0_read: assert property (
        reg_rd && reg_addr == aofp_pkg::OFF_PAT_W0_LOW |=> reg_rdata == $past(reg_w0_low))
        else $error("word 0 low readback wrong");
    chk_w1_read: assert property (
        reg_rd && reg_addr == aofp_pkg::OFF_PAT_W1_HIGH |=> reg_rdata == $past(pat_word1[23:8]))
        else $error("word 1 high readback wrong");
    chk_reset_vals: assert property (
        $past(reset) |-> reg_format == 16'h2002 && reg_scramble == 16'h0002
        && reg_pat_ctrl == 16'h0000 && reg_w0_low == 16'h0000)
        else $error("reset values wrong");
    chk_gain_off: assert property (
        reg_format[aofp_pkg::GAIN_HI:aofp_pkg::GAIN_LO] == 2'h0 |=> !gain_cal_en)
        else $error("gain enable set while field is zero");
    chk_gain_on: assert property (
        reg_format[aofp_pkg::GAIN_HI:aofp_pkg::GAIN_LO] == aofp_pkg::GAIN_ALL_ON
        |=> gain_cal_en)
        else $error("gain enable clear while field is three");
    chk_xor_twos: assert property (
        push && reg_format[aofp_pkg::FMT_BIT] && reg_scramble[aofp_pkg::XOR_BIT]
        |-> proc.b[RW-1:0] == (samp_data.b ^ {RW{samp_data.b[0]}}))
        else $error("scrambled two's complement result wrong");
    chk_pat_ramp: assert property (
        push && pat_on && pat_kind == aofp_pkg::AOFP_PAT_RAMP |-> proc.a == ramp_val)
        else $error("ramp pattern not on lane a");
    chk_pat_alt: assert property (
        push && pat_on && pat_kind == aofp_pkg::AOFP_PAT_ALT
        |-> proc.a == (alt_sel ? pat_word1 : pat_word0))
        else $error("alternate pattern word wrong");
    chk_ramp_hold: assert property (
        !(push && pat_on && pat_kind == aofp_pkg::AOFP_PAT_RAMP) |=> $stable(ramp_val))
        else $error("ramp moved outside ramp mode");
    chk_w0_write: assert property (
        reg_wr && reg_addr == aofp_pkg::OFF_PAT_W0_LOW |=> reg_w0_low == $past(reg_wdata))
        else $error("word 0 low write lost");
    chk_mix_read: assert property (
        reg_rd && reg_addr == aofp_pkg::OFF_PAT_MIX
        |=> reg_rdata == $past({pat_word1[7:0], pat_word0[23:16]}))
        else $error("shared pattern byte readback wrong");
    chk_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    chk_out_hold: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output pair dropped while host stalls");
endmodule

////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO with valid and ready on both sides
module aofp_fifo #(
    parameter int W = 48,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = count != '0;
    assign out_data = mem[rptr];
    assign next_count = count + CW'(push) - CW'(pop);

    ////////////////////////////////////////////////////////////////////////
    // Storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    // Pointers, fill level and registered ready
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
        end else begin
            wptr <= push ? PW'(wptr + 1'b1) : wptr;
            rptr <= pop ? PW'(rptr + 1'b1) : rptr;
            count <= next_count;
            in_ready <= next_count != FULL;
        end
    end
endmodule
`default_nettype wire

//--- sim/aofp_host.sv
// Host capture model: takes output pairs and can stall the output lanes
`default_nettype none
module aofp_host (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Test control
    input wire logic stall,
    // Output lanes from the device
    input wire logic out_valid,
    output logic out_ready,
    input wire aofp_pkg::aofp_out_s out_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [47:0] cap[$];
    ////////////////////////////////////////////////////////////////////////
    // Ready changes only after an edge; a pair is taken at the edge it is seen
    always @(posedge clk_sys) begin
        if (!reset && out_valid === 1'b1 && out_ready) begin
            cap.push_back(out_data);
        end
        out_ready <= reset ? 1'b0 : !stall;
    end
endmodule
`default_nettype wire

//--- sim/tb.sv
// Testbench: register access, output format, scramble, patterns and buffering
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic gain_cal_en;
    logic samp_valid = 1'b0;
    logic samp_ready;
    logic out_valid;
    logic out_ready;
    logic stall = 1'b0;
    aofp_pkg::aofp_raw_s samp_data = '0;
    aofp_pkg::aofp_out_s out_data;
    int n_errors = 0;
    int checked = 0;
    int n;
    always #5 clk_sys = ~clk_sys;
    aofp_top DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .gain_cal_en(gain_cal_en), .samp_valid(samp_valid), .samp_ready(samp_ready),
        .samp_data(samp_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data));
    aofp_host host (.clk_sys(clk_sys), .reset(reset), .stall(stall),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk({32'h0, reg_rdata}, {32'h0, exp});
    endtask
    function automatic logic [23:0] fmt(input logic [17:0] r, input logic tw, input logic sc);
        logic [17:0] v;
        v = tw ? r : {~r[17], r[16:0]};
        if (sc) v = v ^ {18{v[0]}};
        fmt = tw ? {{6{v[17]}}, v} : {6'h00, v};
    endfunction
    task automatic fmtset(input logic tw, input logic sc);
        wr(8'h0D, {2'b00, tw, 13'h0002});
        wr(8'h12, {12'h000, sc, 3'h2});
    endtask
    task automatic push(input logic [17:0] a, input logic [17:0] b);
        int k;
        @(posedge clk_sys);
        samp_valid <= 1'b1;
        samp_data <= '{a: a, b: b};
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (samp_ready !== 1'b1 && k < 50);
        samp_valid <= 1'b0;
    endtask
    task automatic got(input logic [23:0] ea, input logic [23:0] eb);
        int k;
        k = 0;
        while (host.cap.size() == 0 && k < 100) begin
            @(posedge clk_sys);
            k++;
        end
        if (host.cap.size() > 0) chk(host.cap.pop_front(), {ea, eb});
        else chk('x, {ea, eb});
    endtask
    task automatic print_verdict();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #50000;
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rd(8'h0D, 16'h2002);
        rd(8'h12, 16'h0002);
        rd(8'h13, 16'h0000);
        rd(8'h14, 16'h0000);
        rd(8'h15, 16'h0000);
        rd(8'h16, 16'h0000);
        rd(8'h20, 16'h0000);
        chk({47'h0, gain_cal_en}, 48'h0);
        $display("test reset_values done");
        wr(8'h14, 16'hA5C3);
        rd(8'h14, 16'hA5C3);
        wr(8'h0D, 16'h2182);
        repeat (2) @(posedge clk_sys);
        #1 chk({47'h0, gain_cal_en}, 48'h1);
        wr(8'h0D, 16'h2082);
        repeat (2) @(posedge clk_sys);
        #1 chk({47'h0, gain_cal_en}, 48'h0);
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            fmtset(m[1], m[0]);
            push(18'h30005, 18'h01234);
            got(fmt(18'h30005, m[1], m[0]), fmt(18'h01234, m[1], m[0]));
        end
        fmtset(1'b1, 1'b0);
        $display("test format_scramble done");
        wr(8'h14, 16'h1234);
        wr(8'h15, 16'hBB56);
        wr(8'h16, 16'hCDEF);
        for (int m = 0; m < 2; m++) begin
            wr(8'h13, {12'h000, m[1:0], 2'b10});
            push(18'h00007, 18'h3FFF0);
            got(24'h561234, fmt(18'h3FFF0, 1'b1, 1'b0));
        end
        wr(8'h13, 16'h00FA);
        for (int i = 0; i < 3; i++) begin
            push(18'h00001, 18'h00002);
            got(24'(i * 16), 24'h000002);
        end
        wr(8'h13, 16'h000A);
        for (int i = 0; i < 2; i++) begin
            push(18'h00001, 18'h00002);
            got(24'(48 + i), 24'h000002);
        end
        wr(8'h13, 16'h000E);
        for (int i = 0; i < 4; i++) begin
            push(18'h00001, 18'h00002);
            got((i % 2) ? 24'hCDEFBB : 24'h561234, 24'h000002);
        end
        wr(8'h13, 16'h0000);
        push(18'h00009, 18'h00003);
        got(24'h000009, 24'h000003);
        $display("test patterns done");
        stall <= 1'b1;
        repeat (3) @(posedge clk_sys);
        n = 0;
        samp_valid <= 1'b1;
        samp_data <= '0;
        repeat (40) begin
            @(posedge clk_sys);
            if (samp_ready === 1'b1) begin
                n++;
                samp_data <= '{a: 18'(n), b: 18'(n)};
            end
        end
        samp_valid <= 1'b0;
        chk(48'(n), 48'd17);
        stall <= 1'b0;
        for (int i = 0; i < n; i++) got(24'(i), 24'(i));
        $display("test buffer_fill done");
        print_verdict();
    end
endmodule
`default_nettype wire
